// File: verilog/imu_cfg_pkg.sv
package imu_cfg_pkg;
	// Register offsets on the register port
	localparam logic [7:0] ADDR_SEC_WRITE_ADDR = 8'h4E;
	localparam logic [7:0] ADDR_SEC_WRITE_BYTE = 8'h4F;
	localparam logic [7:0] ADDR_ERR_MASK = 8'h52;
	localparam logic [7:0] ADDR_PIN_A_ELEC = 8'h53;
	localparam logic [7:0] ADDR_PIN_B_ELEC = 8'h54;
	localparam logic [7:0] ADDR_LATCH_MODE = 8'h55;
	localparam logic [7:0] ADDR_A_FEAT_ROUTE = 8'h56;
	localparam logic [7:0] ADDR_B_FEAT_ROUTE = 8'h57;
	localparam logic [7:0] ADDR_DATA_ROUTE = 8'h58;
	localparam logic [7:0] ADDR_INIT_START = 8'h59;
	localparam logic [7:0] ADDR_INIT_BASE_LOW = 8'h5B;
	localparam logic [7:0] ADDR_INIT_BASE_HIGH = 8'h5C;
	localparam logic [7:0] ADDR_INIT_PAYLOAD = 8'h5E;
	localparam logic [7:0] ADDR_FAULT_FLAGS = 8'h5F;
	localparam logic [7:0] ADDR_SEC_PAD_TRIM = 8'h68;
	localparam logic [7:0] ADDR_GYRO_RETRIM = 8'h69;
	localparam logic [7:0] ADDR_NV_PROGRAM = 8'h6A;
	localparam logic [7:0] ADDR_SERIAL_PORT = 8'h6B;
	localparam logic [7:0] ADDR_PAD_DRIVE = 8'h6C;

	// Values after reset
	localparam logic [7:0] RST_SEC_WRITE_BYTE = 8'h02;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_SEC_PAD_TRIM = 8'h01;
	localparam logic [7:0] RST_PAD_DRIVE = 8'hFF;

	// Pin electrical control field positions
	localparam int PIN_LEVEL_BIT = 1;
	localparam int PIN_DRIVE_TYPE_BIT = 2;
	localparam int PIN_OUT_EN_BIT = 3;
	localparam int PIN_IN_EN_BIT = 4;
	localparam logic [7:0] PIN_ELEC_MASK = 8'h1E;

	// Fault flag positions
	localparam int FAULT_SLOW_BIT = 1;
	localparam int FAULT_FATAL_BIT = 2;
	localparam int FAULT_FEAT_OFF_BIT = 4;

	// Serial port settings positions
	localparam int PRIMARY_3W_BIT = 0;
	localparam int SECONDARY_3W_BIT = 1;
	localparam int SLAVE_ROLE_BIT = 4;
	localparam int MASTER_ROLE_BIT = 5;
	localparam logic [7:0] SERIAL_PORT_MASK = 8'h33;

	// Retrim: bit 2 writable, bit 3 reports readiness
	localparam int RETRIM_RUN_BIT = 2;
	localparam int RETRIM_READY_BIT = 3;

	// Feature route: bit 7 reserved
	localparam int FEATURE_COUNT = 7;
	localparam int DATA_EVT_COUNT = 4;
	localparam int INIT_LOW_BITS = 4;
endpackage : imu_cfg_pkg

// File: verilog/imu_irq_init_if_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module imu_irq_init_if_config_regs
	import imu_cfg_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic [6:0] feature_events,
	input wire logic queue_full_evt,
	input wire logic queue_level_evt,
	input wire logic sample_ready_evt,
	input wire logic [7:0] error_sources,
	input wire logic slow_processing_fault,
	input wire logic fatal_processing_fault,
	input wire logic feature_engine_off_fault,
	input wire logic retrim_ready,
	input wire logic secondary_manual_mode,
	input wire logic irq_latch_clear,
	input wire logic irq_pin_a_in,
	input wire logic irq_pin_b_in,
	output logic irq_pin_a_out,
	output logic irq_pin_a_oe,
	output logic irq_pin_b_out,
	output logic irq_pin_b_oe,
	output logic irq_pin_a_sensed,
	output logic irq_pin_b_sensed,
	output logic error_irq,
	output logic [11:0] init_base_addr,
	output logic init_start_level,
	output logic [7:0] init_payload_data,
	output logic init_payload_strobe,
	output logic processing_halt,
	output logic [7:0] secondary_write_data,
	output logic [7:0] secondary_write_addr,
	output logic secondary_write_start,
	output logic primary_three_wire_select,
	output logic secondary_three_wire_select,
	output logic secondary_master_role,
	output logic secondary_slave_role
);

	typedef struct packed {
		logic [7:0] sec_write_byte;
		logic [7:0] sec_write_addr;
		logic sec_write_start;
		logic [7:0] err_mask;
		logic [7:0] pin_a_elec;
		logic [7:0] pin_b_elec;
		logic latch_mode;
		logic [7:0] a_feat_route;
		logic [7:0] b_feat_route;
		logic [7:0] data_route;
		logic [7:0] init_start;
		logic [3:0] init_base_low;
		logic [7:0] init_base_high;
		logic [7:0] init_payload;
		logic payload_strobe;
		logic [7:0] fault_flags;
		logic [7:0] pad_trim;
		logic retrim_run;
		logic [7:0] nv_program;
		logic [7:0] serial_port;
		logic [7:0] pad_drive;
		logic [7:0] rdata;
		logic a_latched;
		logic b_latched;
		logic a_out;
		logic a_oe;
		logic b_out;
		logic b_oe;
		logic a_sensed;
		logic b_sensed;
		logic err_irq;
		logic halt;
		logic slave_role;
	} state_t;

	// Current and next copies of all block state
	state_t state;
	state_t next_state;
	// Synchronised reset copy used by every state flop
	logic [1:0] reset_sync;
	logic rst_n;

	// Release of the asynchronous reset goes through two flops
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reset_sync <= 2'b00;
		end else begin
			reset_sync <= {reset_sync[0], 1'b1};
		end
	end
	assign rst_n = reset_sync[1];

	// Pin-side event vectors and levels, computed from the current state
	logic [DATA_EVT_COUNT-1:0] data_events;
	logic err_now;
	logic a_raw;
	logic b_raw;
	logic a_active;
	logic b_active;
	logic a_level;
	logic b_level;

	always_comb begin
		err_now = |(error_sources & state.err_mask);
		data_events = {state.err_irq, sample_ready_evt, queue_level_evt,
			queue_full_evt};
		a_raw = |(feature_events & state.a_feat_route[FEATURE_COUNT-1:0]) |
			|(data_events & state.data_route[DATA_EVT_COUNT-1:0]);
		b_raw = |(feature_events & state.b_feat_route[FEATURE_COUNT-1:0]) |
			|(data_events &
			state.data_route[2*DATA_EVT_COUNT-1:DATA_EVT_COUNT]);
		a_active = a_raw | (state.latch_mode & state.a_latched);
		b_active = b_raw | (state.latch_mode & state.b_latched);
		// Polarity: inactive level is the complement of the asserted level
		a_level = state.pin_a_elec[PIN_LEVEL_BIT] ? a_active : ~a_active;
		b_level = state.pin_b_elec[PIN_LEVEL_BIT] ? b_active : ~b_active;
	end

	// Next-state logic: register writes, reads, flags and pin drive
	always_comb begin
		next_state = state;
		next_state.sec_write_start = 1'b0;
		next_state.payload_strobe = 1'b0;
		next_state.err_irq = err_now;

		// Latch: set wins over a clear in the same cycle
		if (!state.latch_mode || irq_latch_clear) begin
			next_state.a_latched = 1'b0;
			next_state.b_latched = 1'b0;
		end
		if (state.latch_mode && a_raw) begin
			next_state.a_latched = 1'b1;
		end
		if (state.latch_mode && b_raw) begin
			next_state.b_latched = 1'b1;
		end

		// Open-drain only sinks: the pad is released for a high level
		next_state.a_out = a_level;
		next_state.a_oe = state.pin_a_elec[PIN_OUT_EN_BIT] &
			(~state.pin_a_elec[PIN_DRIVE_TYPE_BIT] | ~a_level);
		next_state.b_out = b_level;
		next_state.b_oe = state.pin_b_elec[PIN_OUT_EN_BIT] &
			(~state.pin_b_elec[PIN_DRIVE_TYPE_BIT] | ~b_level);
		next_state.a_sensed = irq_pin_a_in &
			state.pin_a_elec[PIN_IN_EN_BIT];
		next_state.b_sensed = irq_pin_b_in &
			state.pin_b_elec[PIN_IN_EN_BIT];

		// Fault flags are sticky until reset
		if (slow_processing_fault) begin
			next_state.fault_flags[FAULT_SLOW_BIT] = 1'b1;
		end
		if (fatal_processing_fault) begin
			next_state.fault_flags[FAULT_FATAL_BIT] = 1'b1;
		end
		if (feature_engine_off_fault) begin
			next_state.fault_flags[FAULT_FEAT_OFF_BIT] = 1'b1;
		end

		// Register writes
		if (reg_write) begin
			case (reg_addr)
				ADDR_SEC_WRITE_ADDR: begin
					next_state.sec_write_addr = reg_wdata;
					next_state.sec_write_start = secondary_manual_mode;
				end
				ADDR_SEC_WRITE_BYTE: begin
					next_state.sec_write_byte = reg_wdata;
				end
				ADDR_ERR_MASK: begin
					next_state.err_mask = reg_wdata;
				end
				// Only bits 4:1 exist; reserved bits read back zero
				ADDR_PIN_A_ELEC: begin
					next_state.pin_a_elec = reg_wdata & PIN_ELEC_MASK;
				end
				ADDR_PIN_B_ELEC: begin
					next_state.pin_b_elec = reg_wdata & PIN_ELEC_MASK;
				end
				ADDR_LATCH_MODE: begin
					next_state.latch_mode = reg_wdata[0];
				end
				ADDR_A_FEAT_ROUTE: begin
					next_state.a_feat_route = reg_wdata;
				end
				ADDR_B_FEAT_ROUTE: begin
					next_state.b_feat_route = reg_wdata;
				end
				ADDR_DATA_ROUTE: begin
					next_state.data_route = reg_wdata;
				end
				ADDR_INIT_START: begin
					next_state.init_start = reg_wdata;
				end
				ADDR_INIT_BASE_LOW: begin
					next_state.init_base_low = reg_wdata[INIT_LOW_BITS-1:0];
				end
				ADDR_INIT_BASE_HIGH: begin
					next_state.init_base_high = reg_wdata;
				end
				ADDR_INIT_PAYLOAD: begin
					next_state.init_payload = reg_wdata;
					next_state.payload_strobe = 1'b1;
				end
				ADDR_SEC_PAD_TRIM: begin
					next_state.pad_trim = reg_wdata;
				end
				// Readiness bit is status only, so just the run bit is kept
				ADDR_GYRO_RETRIM: begin
					next_state.retrim_run = reg_wdata[RETRIM_RUN_BIT];
				end
				ADDR_NV_PROGRAM: begin
					next_state.nv_program = reg_wdata;
				end
				// Mode and role bits only; the rest read zero
				ADDR_SERIAL_PORT: begin
					next_state.serial_port = reg_wdata & SERIAL_PORT_MASK;
				end
				ADDR_PAD_DRIVE: begin
					next_state.pad_drive = reg_wdata;
				end
				// Read-only and unmapped offsets ignore writes
				default: begin
					next_state.rdata = state.rdata;
				end
			endcase
		end

		// Register reads; unmapped offsets return zero
		if (reg_read) begin
			case (reg_addr)
				ADDR_SEC_WRITE_BYTE: next_state.rdata = state.sec_write_byte;
				ADDR_ERR_MASK: next_state.rdata = state.err_mask;
				ADDR_PIN_A_ELEC: next_state.rdata = state.pin_a_elec;
				ADDR_PIN_B_ELEC: next_state.rdata = state.pin_b_elec;
				ADDR_LATCH_MODE: next_state.rdata = {7'h00, state.latch_mode};
				ADDR_A_FEAT_ROUTE: next_state.rdata = state.a_feat_route;
				ADDR_B_FEAT_ROUTE: next_state.rdata = state.b_feat_route;
				ADDR_DATA_ROUTE: next_state.rdata = state.data_route;
				ADDR_INIT_START: next_state.rdata = state.init_start;
				ADDR_INIT_BASE_LOW: next_state.rdata = {4'h0, state.init_base_low};
				ADDR_INIT_BASE_HIGH: next_state.rdata = state.init_base_high;
				ADDR_INIT_PAYLOAD: next_state.rdata = state.init_payload;
				// Reserved fault bits are never set, so they read zero
				ADDR_FAULT_FLAGS: next_state.rdata = state.fault_flags;
				ADDR_SEC_PAD_TRIM: next_state.rdata = state.pad_trim;
				ADDR_GYRO_RETRIM: begin
					next_state.rdata = RST_ZERO;
					next_state.rdata[RETRIM_RUN_BIT] = state.retrim_run;
					next_state.rdata[RETRIM_READY_BIT] = retrim_ready;
				end
				ADDR_NV_PROGRAM: next_state.rdata = state.nv_program;
				ADDR_SERIAL_PORT: next_state.rdata = state.serial_port;
				ADDR_PAD_DRIVE: next_state.rdata = state.pad_drive;
				default: next_state.rdata = RST_ZERO;
			endcase
		end

		// Derived outputs get their own flops so no pin is gate-driven
		next_state.halt = next_state.fault_flags[FAULT_SLOW_BIT] |
			next_state.fault_flags[FAULT_FATAL_BIT];
		// Master role has priority, so slave only when master is off
		next_state.slave_role = next_state.serial_port[SLAVE_ROLE_BIT] &
			~next_state.serial_port[MASTER_ROLE_BIT];
	end

	// State register with reset values
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
			state.sec_write_byte <= RST_SEC_WRITE_BYTE;
			state.pad_trim <= RST_SEC_PAD_TRIM;
			state.pad_drive <= RST_PAD_DRIVE;
			state.a_out <= 1'b1; // Idle level of active-low default
			state.b_out <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// Outputs, each straight from a state flop
	assign reg_rdata = state.rdata;
	assign irq_pin_a_out = state.a_out;
	assign irq_pin_a_oe = state.a_oe;
	assign irq_pin_b_out = state.b_out;
	assign irq_pin_b_oe = state.b_oe;
	assign irq_pin_a_sensed = state.a_sensed;
	assign irq_pin_b_sensed = state.b_sensed;
	assign error_irq = state.err_irq;

	// Initialization load port
	assign init_base_addr = {state.init_base_high, state.init_base_low};
	assign init_start_level = state.init_start[0];
	assign init_payload_data = state.init_payload;
	assign init_payload_strobe = state.payload_strobe;
	assign processing_halt = state.halt;

	// Secondary interface write path
	assign secondary_write_data = state.sec_write_byte;
	assign secondary_write_addr = state.sec_write_addr;
	assign secondary_write_start = state.sec_write_start;

	// Serial port modes and roles
	assign primary_three_wire_select =
		state.serial_port[PRIMARY_3W_BIT];
	assign secondary_three_wire_select =
		state.serial_port[SECONDARY_3W_BIT];
	assign secondary_master_role = state.serial_port[MASTER_ROLE_BIT];
	assign secondary_slave_role = state.slave_role;

endmodule : imu_irq_init_if_config_regs
`default_nettype wire

// File: test/imu_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host on the register port; changes pins only after falling edges
module imu_host_model (
	input wire logic core_clk,
	output logic [7:0] reg_addr,
	output logic reg_write,
	output logic [7:0] reg_wdata,
	output logic reg_read
);
	initial {reg_addr, reg_write, reg_wdata, reg_read} = 18'h0;
	// One access per call, strobe held over exactly one rising edge
	task automatic xfer(input logic w, input logic [7:0] a, d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_write = w;
		reg_read = !w;
		@(negedge core_clk);
		{reg_write, reg_read} = 2'b00;
		reg_wdata = ~d; // Released bus must not show the old byte
	endtask : xfer
endmodule : imu_host_model
`default_nettype wire

// File: test/imu_cfg_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Port checks; only outputs of the block are judged
module imu_cfg_regs_monitor (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] error_sources,
	input wire logic fatal_processing_fault,
	input wire logic secondary_manual_mode,
	input wire logic error_irq,
	input wire logic [11:0] init_base_addr,
	input wire logic [7:0] init_payload_data,
	input wire logic init_payload_strobe,
	input wire logic processing_halt,
	input wire logic [7:0] secondary_write_data,
	input wire logic [7:0] secondary_write_addr,
	input wire logic secondary_write_start,
	input wire logic secondary_master_role,
	input wire logic secondary_slave_role
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// Write taken on this edge
	sequence s_wr(logic [7:0] a);
		reg_write && reg_addr == a;
	endsequence
	property p_payload;
		s_wr(8'h5E) |=> init_payload_strobe && init_payload_data == $past(reg_wdata);
	endproperty
	a_payload: assert property (p_payload) else $error("payload lost");
	property p_base;
		s_wr(8'h5C) |=> init_base_addr[11:4] == $past(reg_wdata);
	endproperty
	a_base: assert property (p_base) else $error("base high wrong");
	property p_err;
		error_sources == 8'h00 |=> !error_irq;
	endproperty
	a_err: assert property (p_err) else $error("error irq unsourced");
	property p_start;
		s_wr(8'h4E) ##0 secondary_manual_mode |=> secondary_write_start
			&& secondary_write_addr == $past(reg_wdata);
	endproperty
	a_start: assert property (p_start) else $error("no write start");
	property p_start_cause;
		secondary_write_start |-> $past(reg_write) && $past(reg_addr) == 8'h4E
			&& $past(secondary_manual_mode);
	endproperty
	a_start_cause: assert property (p_start_cause) else $error("stray start");
	property p_wbyte;
		s_wr(8'h4F) |=> secondary_write_data == $past(reg_wdata);
	endproperty
	a_wbyte: assert property (p_wbyte) else $error("write byte wrong");
	property p_halt;
		fatal_processing_fault |-> ##[1:2] processing_halt ##1 processing_halt;
	endproperty
	a_halt: assert property (p_halt) else $error("no halt");
	property p_roles;
		!(secondary_master_role && secondary_slave_role);
	endproperty
	a_roles: assert property (p_roles) else $error("both roles");
endmodule : imu_cfg_regs_monitor
bind imu_irq_init_if_config_regs imu_cfg_regs_monitor imu_cfg_regs_monitor_inst (.*);
`default_nettype wire

// File: test/imu_irq_init_if_config_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module imu_irq_init_if_config_regs_tb_top;
	logic core_clk = 1'b0, reset_n = 1'b0, rd_seen = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, init_payload_data, d;
	logic [7:0] secondary_write_data, secondary_write_addr;
	logic reg_write, reg_read, irq_pin_a_out, irq_pin_a_oe, irq_pin_b_out;
	logic irq_pin_b_oe, irq_pin_a_sensed, irq_pin_b_sensed, error_irq;
	logic init_start_level, init_payload_strobe, processing_halt;
	logic secondary_write_start, primary_three_wire_select;
	logic secondary_three_wire_select, secondary_master_role;
	logic secondary_slave_role;
	logic [11:0] init_base_addr;
	logic [7:0] error_sources = 8'h00;
	logic [6:0] feature_events = 7'h00;
	logic [2:0] data_evt = 3'h0;
	logic slow_processing_fault = 1'b0, fatal_processing_fault = 1'b0;
	logic feature_engine_off_fault = 1'b0, retrim_ready = 1'b1;
	logic secondary_manual_mode = 1'b1, irq_latch_clear = 1'b0;
	logic ext_a = 1'b1, ext_b = 1'b1;
	wire logic queue_full_evt = data_evt[0];
	wire logic queue_level_evt = data_evt[1];
	wire logic sample_ready_evt = data_evt[2];
	// Pin level: the pad while it drives, else the outside source
	wire logic irq_pin_a_in = irq_pin_a_oe ? irq_pin_a_out : ext_a;
	wire logic irq_pin_b_in = irq_pin_b_oe ? irq_pin_b_out : ext_b;
	int failures = 0, comparisons = 0;
	logic [15:0] notes [$];
	logic [15:0] n;
	// {offset, value}; last entry is an unmapped offset
	localparam logic [15:0] RST_TAB [10] = '{16'h4F02, 16'h5200, 16'h5300,
		16'h5800, 16'h6801, 16'h6CFF, 16'h5F00, 16'h4E00, 16'h6908, 16'h0000};
	localparam logic [15:0] RW_TAB [7] = '{16'h4FFF, 16'h52FF, 16'h531E,
		16'h57FF, 16'h5CFF, 16'h6B33, 16'h5F00};
	// {electrical setup, {oe,out} asserted, {oe,out} idle}
	localparam logic [15:0] PIN_TAB [5] = '{16'h0A32, 16'h0823, 16'h0C20,
		16'h0200, 16'h0E02};
	// {settings, {primary 3w, secondary 3w, master, slave}}
	localparam logic [15:0] SER_TAB [4] = '{16'h310A, 16'h1001, 16'h1205,
		16'h2002};

	imu_irq_init_if_config_regs imu_irq_init_if_config_regs_inst (.*);
	imu_host_model imu_host_model_inst (.*);

	always #12.5 core_clk = ~core_clk;

	// Read data is registered on the read edge and checked at the next falling edge
	always @(posedge core_clk) rd_seen <= reg_read;
	always @(negedge core_clk) begin
		if (rd_seen) begin
			n = notes.pop_front();
			chk(reg_rdata & n[15:8], n[7:0]);
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(negedge core_clk);
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		imu_host_model_inst.xfer(1'b1, a, v);
	endtask : wr
	// Expected byte noted before the read is issued
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, m);
		notes.push_back({m, e});
		imu_host_model_inst.xfer(1'b0, a, 8'h00);
	endtask : rdc
	// Out is masked with oe, so a released pad reads as zero whatever out holds
	function automatic logic [7:0] pin_a();
		return {6'h00, irq_pin_a_oe, irq_pin_a_out & irq_pin_a_oe};
	endfunction : pin_a
	task automatic end_sim();
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim

	// Hang guard
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		end_sim();
	end

	initial begin
		void'($urandom(32'h6fae8e48));
		repeat (20) @(negedge core_clk);
		reset_n = 1'b1;
		tick(4);
		foreach (RST_TAB[i]) begin
			rdc(RST_TAB[i][15:8], RST_TAB[i][7:0], 8'hFF);
		end
		foreach (RW_TAB[i]) begin
			d = 8'($urandom);
			wr(RW_TAB[i][15:8], d);
			rdc(RW_TAB[i][15:8], d & RW_TAB[i][7:0], 8'hFF);
		end
		$display("test registers done");
		wr(8'h58, 8'h00);
		wr(8'h56, 8'h01);
		foreach (PIN_TAB[i]) begin
			wr(8'h53, PIN_TAB[i][15:8]);
			feature_events = 7'h7E;
			tick(2);
			chk(pin_a(), {4'h0, PIN_TAB[i][3:0]});
			feature_events = 7'h01;
			tick(2);
			chk(pin_a(), {4'h0, PIN_TAB[i][7:4]});
		end
		feature_events = 7'h00;
		wr(8'h53, 8'h0A);
		for (int k = 0; k < 3; k++) begin
			wr(8'h58, 8'(1 << k));
			data_evt = 3'(~(1 << k));
			tick(2);
			chk(pin_a(), 8'h02);
			data_evt = 3'(1 << k);
			tick(2);
			chk(pin_a(), 8'h03);
		end
		data_evt = 3'h0;
		wr(8'h58, 8'h08);
		wr(8'h52, 8'h40);
		error_sources = 8'hBF;
		tick(3);
		chk(pin_a(), 8'h02);
		error_sources = 8'h40;
		tick(3);
		chk(pin_a(), 8'h03);
		error_sources = 8'h00;
		wr(8'h54, 8'h0A);
		wr(8'h57, 8'h40);
		wr(8'h58, 8'h10);
		feature_events = 7'h40;
		data_evt = 3'h1;
		tick(2);
		chk({irq_pin_b_oe, irq_pin_b_out, 4'h0, irq_pin_a_oe,
			irq_pin_a_out & irq_pin_a_oe}, 8'hC2);
		$display("test routing done");
		wr(8'h55, 8'h01);
		feature_events = 7'h01;
		tick(1);
		{feature_events, data_evt} = 10'h000;
		tick(3);
		chk(pin_a(), 8'h03);
		irq_latch_clear = 1'b1;
		tick(1);
		irq_latch_clear = 1'b0;
		tick(2);
		chk(pin_a(), 8'h02);
		wr(8'h53, 8'h10);
		wr(8'h54, 8'h10);
		tick(2);
		chk({6'h00, irq_pin_b_sensed, irq_pin_a_sensed}, 8'h03);
		wr(8'h53, 8'h00);
		wr(8'h54, 8'h00);
		tick(2);
		chk({6'h00, irq_pin_b_sensed, irq_pin_a_sensed}, 8'h00);
		$display("test latch_sense done");
		slow_processing_fault = 1'b1;
		tick(1);
		{slow_processing_fault, feature_engine_off_fault} = 2'b01;
		tick(1);
		feature_engine_off_fault = 1'b0;
		rdc(8'h5F, 8'h12, 8'h16);
		fatal_processing_fault = 1'b1;
		tick(1);
		fatal_processing_fault = 1'b0;
		rdc(8'h5F, 8'h16, 8'h16);
		chk(8'(processing_halt), 8'h01);
		foreach (SER_TAB[i]) begin
			wr(8'h6B, SER_TAB[i][15:8]);
			tick(1);
			chk(8'({primary_three_wire_select, secondary_three_wire_select,
				secondary_master_role, secondary_slave_role}), SER_TAB[i][7:0]);
		end
		wr(8'h5C, 8'h12);
		wr(8'h5B, 8'h34);
		for (int k = 0; k < 4; k++) begin
			d = 8'($urandom);
			wr(8'h5E, d);
			chk(init_payload_data, d);
		end
		chk(init_base_addr[11:4], 8'h12);
		wr(8'h59, 8'h01);
		chk(8'(init_start_level), 8'h01);
		wr(8'h5B, 8'h36);
		wr(8'h4E, 8'h5A);
		tick(1);
		chk({4'h0, init_base_addr[3:0]}, 8'h06);
		chk(secondary_write_addr, 8'h5A);
		secondary_manual_mode = 1'b0;
		wr(8'h4E, 8'hA5);
		tick(1);
		chk(secondary_write_addr, 8'hA5);
		secondary_manual_mode = 1'b1;
		$display("test faults_serial_init done");
		tick(2);
		end_sim();
	end
endmodule : imu_irq_init_if_config_regs_tb_top
`default_nettype wire
